// ---- core/seepi_defs.svh ----
// Purpose: constants of the serial eeprom pin front end
// Assumes: included by bare name from the core only; the package does not include it
// Notes:   opcode low bits select the command, bit 3 is don't care or A8
`ifndef SEEPI_DEFS_SVH
`define SEEPI_DEFS_SVH

`define SEEPI_OP_HI_POS    7:4
`define SEEPI_OP_HI_VAL    4'h0
`define SEEPI_OP_A8_POS    3
`define SEEPI_OP_LO_POS    2:0
`define SEEPI_OP_WREN      3'h6
`define SEEPI_OP_WRDI      3'h4
`define SEEPI_OP_RDSR      3'h5
`define SEEPI_OP_STWR      3'h1
`define SEEPI_OP_READ      3'h3
`define SEEPI_OP_WRITE     3'h2
`define SEEPI_ST_LATCH_POS 1
`define SEEPI_ST_WIP_POS   0
`define SEEPI_ST_HI_VAL    4'h0
`define SEEPI_BIT_LAST     3'h7
`define SEEPI_PIN_W        5
`define SEEPI_PIN_RST      5'h13

`endif

// ---- core/seepi_pkg.sv ----
// Purpose: types of the serial eeprom pin front end
// Assumes: constants live in seepi_defs.svh
// Notes:   none
package seepi_pkg;
  typedef enum logic [2:0] {
    SEEPI_IDLE   = 3'h0,
    SEEPI_OPC    = 3'h1,
    SEEPI_ADDR   = 3'h2,
    SEEPI_DATA   = 3'h3,
    SEEPI_IGNORE = 3'h4
  } seepi_state_t;
endpackage : seepi_pkg

// ---- core/seepi_sync.sv ----
// Purpose: two flip-flop synchroniser for a group of pin levels
// Assumes: each bit is an independent level
// Notes:   reset value is a constant parameter
`timescale 1ns/100ps
module seepi_sync #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_r <= RST;
      q      <= RST;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : seepi_sync

// ---- core/seepi_core.sv ----
// Purpose: pin front end of a serial eeprom, device side
// Assumes: memory array and nonvolatile programming sit outside
// Notes:   pins are oversampled by clk_sys; edges come from the synchronised levels
`timescale 1ns/100ps
`include "seepi_defs.svh"
module seepi_core
  import seepi_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       cs_n_pin,
  input  wire logic       sck_pin,
  input  wire logic       si_pin,
  input  wire logic       wp_n_pin,
  input  wire logic       hold_n_pin,
  output logic            so_out,
  output logic            so_oe,
  input  wire logic [1:0] bp_i,
  input  wire logic       prog_busy_i,
  input  wire logic [7:0] rd_data_i,
  output logic            rd_req_o,
  output logic [8:0]      mem_addr_o,
  output logic            wr_byte_o,
  output logic [7:0]      wr_data_o,
  output logic            prog_start_o,
  output logic            prog_status_o,
  output logic            write_enable_latch,
  output logic            standby_o,
  output logic            active_o
);
  logic [4:0]   pin_q;
  logic         cs_q;
  logic         sck_q;
  logic         si_q;
  logic         wp_q;
  logic         hold_q;
  logic         hold_act;
  logic         sck_rise;
  logic         sck_fall;
  logic         op_ok;
  logic [7:0]   rx_byte;
  logic [7:0]   src_byte;
  logic [7:0]   status_byte;
  logic         prog_done;

  seepi_state_t state_r,    state_nxt;
  logic         sck_d_r,    sck_d_nxt;
  logic [2:0]   bit_cnt_r,  bit_cnt_nxt;
  logic [7:0]   rx_sh_r,    rx_sh_nxt;
  logic [7:0]   tx_sh_r,    tx_sh_nxt;
  logic [7:0]   opc_r,      opc_nxt;
  logic         got_byte_r, got_byte_nxt;
  logic         oe_r,       oe_nxt;
  logic         so_r,       so_nxt;
  logic         latch_r,    latch_nxt;
  logic         busy_d_r,   busy_d_nxt;
  logic [8:0]   addr_r,     addr_nxt;
  logic         rd_req_r,   rd_req_nxt;
  logic         wr_byte_r,  wr_byte_nxt;
  logic [7:0]   wr_data_r,  wr_data_nxt;
  logic         prog_r,     prog_nxt;
  logic         prog_st_r,  prog_st_nxt;

  // pins are asynchronous to clk_sys
  seepi_sync #(.W(`SEEPI_PIN_W), .RST(`SEEPI_PIN_RST)) u_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d       ({cs_n_pin, sck_pin, si_pin, wp_n_pin, hold_n_pin}),
    .q       (pin_q)
  );
  assign {cs_q, sck_q, si_q, wp_q, hold_q} = pin_q;

  // sck history keeps running through a pause so release makes no false edge
  assign hold_act  = !hold_q && !cs_q;
  assign sck_rise  = sck_q && !sck_d_r && !hold_act;
  assign sck_fall  = !sck_q && sck_d_r && !hold_act;
  assign rx_byte   = {rx_sh_r[6:0], si_q};
  assign op_ok     = (rx_byte[`SEEPI_OP_HI_POS] == `SEEPI_OP_HI_VAL) &&
                     (rx_byte[`SEEPI_OP_LO_POS] != 3'h0) &&
                     (rx_byte[`SEEPI_OP_LO_POS] != 3'h7);
  assign status_byte = {`SEEPI_ST_HI_VAL, bp_i, latch_r, prog_busy_i};
  assign src_byte  = (opc_r[`SEEPI_OP_LO_POS] == `SEEPI_OP_RDSR) ? status_byte : rd_data_i;
  assign prog_done = busy_d_r && !prog_busy_i;

  always_comb begin
    state_nxt    = state_r;
    sck_d_nxt    = sck_q;
    bit_cnt_nxt  = bit_cnt_r;
    rx_sh_nxt    = rx_sh_r;
    tx_sh_nxt    = tx_sh_r;
    opc_nxt      = opc_r;
    got_byte_nxt = got_byte_r;
    oe_nxt       = oe_r;
    so_nxt       = so_r;
    latch_nxt    = latch_r;
    busy_d_nxt   = prog_busy_i;
    addr_nxt     = addr_r;
    rd_req_nxt   = 1'b0;
    wr_byte_nxt  = 1'b0;
    wr_data_nxt  = wr_data_r;
    prog_nxt     = 1'b0;
    prog_st_nxt  = prog_st_r;
    if (prog_done) begin
      latch_nxt = 1'b0;
    end
    if (cs_q) begin
      // frame ends on select release; commands act only on a clean byte count
      if (state_r == SEEPI_DATA && bit_cnt_r == 3'h0) begin
        unique case (opc_r[`SEEPI_OP_LO_POS])
          `SEEPI_OP_WREN: if (!got_byte_r) latch_nxt = 1'b1;
          `SEEPI_OP_WRDI: if (!got_byte_r) latch_nxt = 1'b0;
          `SEEPI_OP_STWR, `SEEPI_OP_WRITE: begin
            if (got_byte_r && latch_r && wp_q && !prog_busy_i) begin
              prog_nxt    = 1'b1;
              prog_st_nxt = (opc_r[`SEEPI_OP_LO_POS] == `SEEPI_OP_STWR);
            end
          end
          default: ;
        endcase
      end
      state_nxt   = SEEPI_IDLE;
      bit_cnt_nxt = 3'h0;
      oe_nxt      = 1'b0;
    end else if (state_r == SEEPI_IDLE) begin
      state_nxt    = SEEPI_OPC;
      bit_cnt_nxt  = 3'h0;
      got_byte_nxt = 1'b0;
    end else begin
      if (sck_rise) begin
        rx_sh_nxt   = rx_byte;
        bit_cnt_nxt = bit_cnt_r + 3'h1;
        if (bit_cnt_r == `SEEPI_BIT_LAST) begin
          unique case (state_r)
            SEEPI_OPC: begin
              opc_nxt = rx_byte;
              if (!op_ok) begin
                state_nxt = SEEPI_IGNORE;
              end else if (rx_byte[`SEEPI_OP_LO_POS] == `SEEPI_OP_READ ||
                           rx_byte[`SEEPI_OP_LO_POS] == `SEEPI_OP_WRITE) begin
                state_nxt   = SEEPI_ADDR;
                addr_nxt[8] = rx_byte[`SEEPI_OP_A8_POS];
              end else begin
                state_nxt = SEEPI_DATA;
              end
            end
            SEEPI_ADDR: begin
              addr_nxt[7:0] = rx_byte;
              state_nxt     = SEEPI_DATA;
              rd_req_nxt    = (opc_r[`SEEPI_OP_LO_POS] == `SEEPI_OP_READ);
            end
            SEEPI_DATA: begin
              got_byte_nxt = 1'b1;
              if (opc_r[`SEEPI_OP_LO_POS] == `SEEPI_OP_READ) begin
                addr_nxt   = addr_r + 9'h001;
                rd_req_nxt = 1'b1;
              end else if (opc_r[`SEEPI_OP_LO_POS] == `SEEPI_OP_WRITE ||
                           opc_r[`SEEPI_OP_LO_POS] == `SEEPI_OP_STWR) begin
                wr_byte_nxt = 1'b1;
                wr_data_nxt = rx_byte;
                if (opc_r[`SEEPI_OP_LO_POS] == `SEEPI_OP_WRITE) begin
                  addr_nxt = addr_r + 9'h001;
                end
              end
            end
            default: ;
          endcase
        end
      end
      if (sck_fall && state_r == SEEPI_DATA &&
          (opc_r[`SEEPI_OP_LO_POS] == `SEEPI_OP_RDSR ||
           opc_r[`SEEPI_OP_LO_POS] == `SEEPI_OP_READ)) begin
        oe_nxt = 1'b1;
        if (bit_cnt_r == 3'h0) begin
          so_nxt    = src_byte[7];
          tx_sh_nxt = {src_byte[6:0], 1'b0};
        end else begin
          so_nxt    = tx_sh_r[7];
          tx_sh_nxt = {tx_sh_r[6:0], 1'b0};
        end
      end
    end
    // protect pin wins over a latch set in the same cycle
    if (!wp_q) begin
      latch_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r    <= SEEPI_IDLE;
      sck_d_r    <= 1'b0;
      bit_cnt_r  <= 3'h0;
      rx_sh_r    <= 8'h00;
      tx_sh_r    <= 8'h00;
      opc_r      <= 8'h00;
      got_byte_r <= 1'b0;
      oe_r       <= 1'b0;
      so_r       <= 1'b0;
      latch_r    <= 1'b0;
      busy_d_r   <= 1'b0;
      addr_r     <= 9'h000;
      rd_req_r   <= 1'b0;
      wr_byte_r  <= 1'b0;
      wr_data_r  <= 8'h00;
      prog_r     <= 1'b0;
      prog_st_r  <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      sck_d_r    <= sck_d_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      rx_sh_r    <= rx_sh_nxt;
      tx_sh_r    <= tx_sh_nxt;
      opc_r      <= opc_nxt;
      got_byte_r <= got_byte_nxt;
      oe_r       <= oe_nxt;
      so_r       <= so_nxt;
      latch_r    <= latch_nxt;
      busy_d_r   <= busy_d_nxt;
      addr_r     <= addr_nxt;
      rd_req_r   <= rd_req_nxt;
      wr_byte_r  <= wr_byte_nxt;
      wr_data_r  <= wr_data_nxt;
      prog_r     <= prog_nxt;
      prog_st_r  <= prog_st_nxt;
    end
  end

  assign so_out             = so_r;
  assign so_oe              = oe_r && !cs_q && !hold_act;
  assign rd_req_o           = rd_req_r;
  assign mem_addr_o         = addr_r;
  assign wr_byte_o          = wr_byte_r;
  assign wr_data_o          = wr_data_r;
  assign prog_start_o       = prog_r;
  assign prog_status_o      = prog_st_r;
  assign write_enable_latch = latch_r;
  assign standby_o          = cs_q && !prog_busy_i;
  assign active_o           = !cs_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_opc_bad;
    state_r == SEEPI_OPC && !cs_q && sck_rise && bit_cnt_r == `SEEPI_BIT_LAST && !op_ok;
  endsequence
  sequence s_hold_on;
    hold_act && state_r != SEEPI_IDLE;
  endsequence

  a_desel_hiz_out: assert property (cs_q |-> !so_oe ##1 state_r == SEEPI_IDLE)
    else $error("output driven or state kept while deselected");
  a_standby_idle: assert property ($rose(cs_q) && !prog_busy_i |-> standby_o && !active_o)
    else $error("not in standby after deselect");
  a_rx_on_rise: assert property ($changed(rx_sh_r) |-> $past(sck_rise))
    else $error("serial input shifted without a rising edge");
  a_so_on_fall: assert property ($changed(so_r) |-> $past(sck_fall))
    else $error("serial output changed without a falling edge");
  a_wp_clears_latch: assert property (!wp_q |=> !latch_r)
    else $error("write enable latch kept under write protect");
  a_prog_needs_wp: assert property (prog_start_o |-> $past(wp_q))
    else $error("programming started under write protect");
  a_prog_needs_latch: assert property (prog_start_o |-> $past(latch_r))
    else $error("programming started with latch clear");
  // output checked in the paused cycle itself; release may re-enable it one cycle later
  a_hold_freezes: assert property (s_hold_on |-> !so_oe ##1 $stable(bit_cnt_r))
    else $error("transfer advanced or output driven while paused");
  a_bad_op_drop: assert property (s_opc_bad |=> state_r == SEEPI_IGNORE [*1] ##1 !oe_r)
    else $error("invalid instruction not dropped");
endmodule : seepi_core

// ---- sim/seepi_host.sv ----
// Purpose: host controller model driving select, clock, data and pause pins
// Assumes: mode 0, serial clock idles low and stands still outside frames
// Notes:   a released output line reads as the inverse of its last level
`timescale 1ns/100ps
module seepi_host (
  output logic      cs_n_pin,
  output logic      sck_pin,
  output logic      si_pin,
  output logic      hold_n_pin,
  input  wire logic so_out,
  input  wire logic so_oe
);
  localparam realtime HALF = 62.5;
  logic so_seen;
  initial begin
    cs_n_pin   = 1'b1;
    sck_pin    = 1'b0;
    si_pin     = 1'b0;
    hold_n_pin = 1'b1;
    so_seen    = 1'b0;
  end
  task automatic sel();
    cs_n_pin = 1'b0; // every frame opens with select low; all but the select test then send an opcode
    #(2*HALF);
  endtask : sel
  task automatic desel();
    #HALF;
    cs_n_pin = 1'b1;
    si_pin   = ~si_pin;
    #(4*HALF);
  endtask : desel
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si_pin = tx[i]; // msb first, set while clock low
      #HALF;
      sck_pin = 1'b1;
      rx[i]   = so_oe ? so_out : ~so_seen;
      so_seen = rx[i];
      #HALF;
      sck_pin = 1'b0;
    end
  endtask : xfer
  // pause only with clock low and select held low; clock and data churn meanwhile
  task automatic pause(input int n);
    // keep clear of the last falling edge so it still loads the next output bit
    #(HALF/2);
    hold_n_pin = 1'b0;
    #HALF;
    repeat (n) begin
      sck_pin = 1'b1;
      si_pin  = ~si_pin;
      #HALF;
      sck_pin = 1'b0;
      #HALF;
    end
    hold_n_pin = 1'b1;
    #HALF;
  endtask : pause
endmodule : seepi_host

// ---- sim/tb.sv ----
// Purpose: self-checking bench of the serial eeprom pin front end
// Assumes: memory contents are a fixed pattern of the address
// Notes:   programming busy lasts 30 system clocks after each start pulse
`timescale 1ns/100ps
module tb;
  import seepi_pkg::*;
  logic       clk_sys, rstn, wp_n_pin, prog_busy_i;
  logic [1:0] bp_i;
  wire logic  cs_n_pin, sck_pin, si_pin, hold_n_pin, so_out, so_oe, rd_req_o, wr_byte_o;
  wire logic  prog_start_o, prog_status_o, write_enable_latch, standby_o, active_o;
  wire logic [8:0] mem_addr_o;
  wire logic [7:0] wr_data_o, rd_data_i;
  logic [7:0] rx, last_wr;
  logic       last_st;
  int         n_fail, total_checks, n_prog, n_wrb, n_rdq, busy_cnt;

  function automatic logic [7:0] mem_val(input logic [8:0] a);
    return a[7:0] ^ 8'h5a ^ {a[8], 7'h00};
  endfunction : mem_val
  assign rd_data_i = mem_val(mem_addr_o);

  seepi_host host (.cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .si_pin(si_pin),
                   .hold_n_pin(hold_n_pin), .so_out(so_out), .so_oe(so_oe));
  seepi_core dut (.clk_sys(clk_sys), .rstn(rstn), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin),
    .si_pin(si_pin), .wp_n_pin(wp_n_pin), .hold_n_pin(hold_n_pin), .so_out(so_out),
    .so_oe(so_oe), .bp_i(bp_i), .prog_busy_i(prog_busy_i), .rd_data_i(rd_data_i),
    .rd_req_o(rd_req_o), .mem_addr_o(mem_addr_o), .wr_byte_o(wr_byte_o),
    .wr_data_o(wr_data_o), .prog_start_o(prog_start_o), .prog_status_o(prog_status_o),
    .write_enable_latch(write_enable_latch), .standby_o(standby_o), .active_o(active_o));

  always #5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) begin
    if (prog_start_o === 1'b1) busy_cnt = 30;
    else if (busy_cnt > 0) busy_cnt--;
    prog_busy_i <= (busy_cnt > 0);
  end
  always @(negedge clk_sys) begin
    if (prog_start_o === 1'b1) begin n_prog++; last_st = prog_status_o; end
    if (wr_byte_o === 1'b1) begin n_wrb++; last_wr = wr_data_o; end
    if (rd_req_o === 1'b1) n_rdq++;
  end
  // output may only move while the serial clock is low
  always @(so_out) if (rstn === 1'b1 && so_oe === 1'b1 && sck_pin === 1'b1) begin
    n_fail++;
    $display("CHECK FAILED so_out expected stable seen change");
  end

  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  task automatic cmd(input logic [7:0] op);
    host.sel();
    host.xfer(op, rx);
    host.desel();
  endtask : cmd
  task automatic rdsr(input logic latch);
    host.sel();
    host.xfer(8'h05, rx);
    host.xfer(8'hff, rx);
    host.desel();
    check("status", {4'h0, bp_i, latch, 1'b0}, rx);
  endtask : rdsr
  task automatic wait_idle();
    int k;
    for (k = 0; k < 200 && prog_busy_i !== 1'b0; k++) @(negedge clk_sys);
    if (k == 200) begin n_fail++; finish_test(); end
    repeat (4) @(negedge clk_sys);
  endtask : wait_idle
  task automatic wr_frame(input logic [7:0] op, input logic [7:0] b);
    host.sel();
    host.xfer(op, rx);
    // a status write takes its data byte where a memory write takes the address
    host.xfer((op == 8'h02) ? 8'h35 : b, rx);
    if (op == 8'h02) host.xfer(b, rx);
    host.desel();
  endtask : wr_frame

  task automatic t_select();
    check("oe idle", 0, so_oe);
    check("standby idle", 1, standby_o);
    host.sel();
    check("active", 1, active_o);
    check("standby sel", 0, standby_o);
    host.desel();
    $display("test select done");
  endtask : t_select
  task automatic t_wel();
    cmd(8'h06);
    check("latch set", 1, write_enable_latch);
    rdsr(1'b1);
    cmd(8'h04);
    rdsr(1'b0);
    $display("test latch done");
  endtask : t_wel
  task automatic t_write();
    logic [7:0] ops [2] = '{8'h02, 8'h01};
    int np;
    int nw;
    foreach (ops[i]) begin
      cmd(8'h06);
      np = n_prog;
      nw = n_wrb;
      wr_frame(ops[i], 8'ha5);
      check("prog start", np + 1, n_prog[8:0]);
      check("byte pulses", nw + 1, n_wrb[8:0]);
      check("prog kind", ops[i][0], last_st);
      check("standby busy", 0, standby_o);
      wait_idle();
      check("latch after", 0, write_enable_latch);
      np = n_prog;
      wr_frame(ops[i], 8'h3c);
      check("no prog", np, n_prog[8:0]);
    end
    check("data byte", 8'h3c, last_wr);
    $display("test write done");
  endtask : t_write
  task automatic t_protect();
    int np;
    cmd(8'h06);
    @(negedge clk_sys) wp_n_pin <= 1'b0;
    repeat (6) @(negedge clk_sys);
    check("wp clears", 0, write_enable_latch);
    cmd(8'h06);
    check("wp holds", 0, write_enable_latch);
    np = n_prog;
    wr_frame(8'h02, 8'h11);
    check("wp refuse", np, n_prog[8:0]);
    rdsr(1'b0);
    @(negedge clk_sys) wp_n_pin <= 1'b1;
    $display("test protect done");
  endtask : t_protect
  task automatic t_hold();
    int nr;
    nr = n_rdq;
    host.sel();
    host.xfer(8'h0b, rx);
    host.xfer(8'h12, rx);
    host.xfer(8'hff, rx);
    check("read 0", mem_val(9'h112), rx);
    fork
      host.pause(4);
      begin #200 check("oe paused", 0, so_oe); end
    join
    host.xfer(8'hff, rx);
    check("read 1", mem_val(9'h113), rx);
    check("addr step", 9'h114, mem_addr_o);
    host.desel();
    check("oe desel", 0, so_oe);
    check("read requests", nr + 3, n_rdq[8:0]);
    $display("test hold done");
  endtask : t_hold
  task automatic t_invalid();
    logic [7:0] ops [2] = '{8'h85, 8'h07};
    foreach (ops[i]) begin
      host.sel();
      host.xfer(ops[i], rx);
      host.xfer(8'h00, rx);
      check("oe invalid", 0, so_oe);
      host.desel();
    end
    cmd(8'h46);
    check("latch invalid", 0, write_enable_latch);
    rdsr(1'b0);
    $display("test invalid done");
  endtask : t_invalid

  initial begin
    clk_sys = 1'b0;
    rstn = 1'b0;
    wp_n_pin = 1'b1; // driven to a defined level throughout
    bp_i = 2'h2;
    repeat (4) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_select();
    t_wel();
    t_write();
    t_protect();
    t_hold();
    t_invalid();
    finish_test();
  end
endmodule : tb
